// ### hdl/fts_pkg.sv
// Constants and types for the flow-through burst SRAM port
// Contract
// (RL1) Array holds 524288 words of 36 bits, four byte lanes of nine bits.
// (RL2) All synchronous inputs are captured on the rising clock edge; controller keeps them valid.
// (RL3) With clock qualify high, edges are ignored and all state and outputs hold.
// (RL4) Reads and writes mix freely, write then read included, one word every qualified clock.
// (RL5) Write strobe plus per-lane selects decide writes; only low-selected lanes change.
// (RL6) Writes complete internally, no external write pulse needed.
// (RL7) Selected only when first and third selects are low and second is high.
// (RL8) Output enable high turns data drivers off at once, without a clock.
// (RL9) Data drivers turn off during the data cycle of every write.
// (RL10) Bursts run linear or interleaved, picked by a static mode input.
// (RL11) Low-power state on sleep input or on deselect.
// (RL12) Low two address bits seed a two-bit burst counter for later burst cycles.
// (RL13) Step/load high advances the burst counter; low loads a new address.
// (RL14) Controller loads a new address after a deselect before any access.
// (RL15) Controller drives write strobe low to write; high with selection reads.
// (RL16) Read data appears in the cycle right after its address edge.
// (RL17) Controller drives write data one cycle after the write's address cycle.
package fts_pkg;

  // ==========================================================================
  // Geometry
  localparam int ADDR_W      = 19;
  localparam int WORD_W      = 36;
  localparam int LANES       = 4;
  localparam int LANE_W      = 9;
  localparam int ARRAY_WORDS = 524288;
  localparam int BURST_W     = 2;
  localparam int FIFO_DEPTH  = 16;

  // ==========================================================================
  // Reset values
  localparam logic [ADDR_W-1:0]  ADDR_RST  = 19'h00000;
  localparam logic [WORD_W-1:0]  WORD_RST  = 36'h000000000;
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
  localparam logic [LANES-1:0]   LANES_RST = 4'hf;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    FTS_OP_IDLE  = 2'b00,
    FTS_OP_READ  = 2'b01,
    FTS_OP_WRITE = 2'b10
  } fts_op_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  lanes_n;
    logic [WORD_W-1:0] data;
  } fts_entry_t;

  localparam int ENTRY_W = $bits(fts_entry_t);

endpackage

// ### hdl/fts_fifo_if.sv
// Interface between the port logic and its write queue
`timescale 1ns/10ps
`default_nettype none

interface fts_fifo_if #(
  parameter int W = 8,
  parameter int D = 16
) ();
  logic                push_valid;
  logic                push_ready;
  logic [W-1:0]        push_data;
  logic                pop_valid;
  logic                pop_ready;
  logic [W-1:0]        pop_data;
  // Oldest entry first, so a reader can forward pending writes in order
  logic [D-1:0][W-1:0] snap;
  logic [D-1:0]        live;

  modport fifo (
    input  push_valid, push_data, pop_ready,
    output push_ready, pop_valid, pop_data, snap, live
  );

  modport user (
    output push_valid, push_data, pop_ready,
    input  push_ready, pop_valid, pop_data, snap, live
  );
endinterface

`default_nettype wire

// ### hdl/fts_fifo.sv
// Parameterised FIFO with a full view of its pending entries
`timescale 1ns/10ps
`default_nettype none

module fts_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  fts_fifo_if.fifo  q
);
  localparam int PW = $clog2(D);

  typedef struct packed {
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0]   count;
  } fts_fifo_state_t;

  fts_fifo_state_t st;
  fts_fifo_state_t next_st;
  logic [W-1:0]    store [D];
  logic            push;
  logic            pop;
  logic            full;

  assign full         = (st.count == (PW+1)'(D));
  // A pop in the same cycle frees the slot, so a full queue still takes a word
  assign q.push_ready = !full || q.pop_ready;
  assign q.pop_valid  = (st.count != '0);
  assign q.pop_data   = store[st.rd];

  always_comb begin
    push    = q.push_valid && q.push_ready;
    pop     = q.pop_valid && q.pop_ready;
    next_st = st;
    if (push) begin
      next_st.wr = st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = st.rd + 1'b1;
    end
    case ({push, pop})
      2'b10:   next_st.count = st.count + 1'b1;
      2'b01:   next_st.count = st.count - 1'b1;
      default: next_st.count = st.count;
    endcase
  end

  always_comb begin
    for (int i = 0; i < D; i++) begin
      q.snap[i] = store[st.rd + PW'(i)];
      q.live[i] = ((PW+1)'(i) < st.count);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      store[st.wr] <= q.push_data;
    end
  end

  a_fifo_no_overrun: assert property (@(posedge clk_i) disable iff (rst_i)
    full && q.push_valid |-> q.pop_ready)
    else $error("Word pushed into a full queue without a pop");

endmodule

`default_nettype wire

// ### hdl/fts_sram_port.sv
// Flow-through burst SRAM port with self-timed write queue
`timescale 1ns/10ps
`default_nettype none

module fts_sram_port (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic [fts_pkg::ADDR_W-1:0] addr_i,
  input  wire logic                      select_low_first_n_i,
  input  wire logic                      select_high_second_i,
  input  wire logic                      select_low_third_n_i,
  input  wire logic                      clock_qualify_n_i,
  input  wire logic                      write_n_i,
  input  wire logic [fts_pkg::LANES-1:0] lane_write_sel_n_i,
  input  wire logic                      burst_step_or_load_i,
  input  wire logic                      burst_interleave_i,
  input  wire logic                      sleep_pin_i,
  input  wire logic                      out_enable_n_i,
  input  wire logic [fts_pkg::WORD_W-1:0] dq_i,
  output logic      [fts_pkg::WORD_W-1:0] dq_o,
  output logic                           dq_oe_o,
  output logic                           low_power_o
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [fts_pkg::ADDR_W-1:0]  base;
    logic [fts_pkg::BURST_W-1:0] start;
    logic [fts_pkg::BURST_W-1:0] cnt;
    fts_pkg::fts_op_t            last_op;
    logic                        pend_wr;
    logic [fts_pkg::ADDR_W-1:0]  pend_addr;
    logic [fts_pkg::LANES-1:0]   pend_lanes;
    logic [fts_pkg::WORD_W-1:0]  dq;
    logic                        drive;
    logic                        low_power;
  } fts_state_t;

  fts_state_t                 st;
  fts_state_t                 next_st;
  logic [fts_pkg::WORD_W-1:0] array_q [fts_pkg::ARRAY_WORDS];

  logic                        qual;
  logic                        chip_sel;
  logic                        load;
  fts_pkg::fts_op_t            op;
  logic [fts_pkg::ADDR_W-1:0]  eff_addr;
  logic [fts_pkg::BURST_W-1:0] step_cnt;
  logic [fts_pkg::WORD_W-1:0]  read_word;
  fts_pkg::fts_entry_t         push_entry;
  fts_pkg::fts_entry_t         head;

  fts_fifo_if #(
    .W (fts_pkg::ENTRY_W),
    .D (fts_pkg::FIFO_DEPTH)
  ) wq ();

  // ==========================================================================
  // Helpers
  function automatic logic [fts_pkg::WORD_W-1:0] fts_merge(
    input logic [fts_pkg::WORD_W-1:0] old_word,
    input logic [fts_pkg::WORD_W-1:0] new_word,
    input logic [fts_pkg::LANES-1:0]  lanes_n
  );
    logic [fts_pkg::WORD_W-1:0] w;
    w = old_word;
    for (int k = 0; k < fts_pkg::LANES; k++) begin
      if (!lanes_n[k]) begin
        w[k*fts_pkg::LANE_W +: fts_pkg::LANE_W] = new_word[k*fts_pkg::LANE_W +: fts_pkg::LANE_W]; // RL5
      end
    end
    return w;
  endfunction

  function automatic logic [fts_pkg::BURST_W-1:0] fts_burst_low(
    input logic [fts_pkg::BURST_W-1:0] start,
    input logic [fts_pkg::BURST_W-1:0] cnt,
    input logic                        interleave
  );
    // Sum wraps inside the two-bit field, which is the linear wrap order
    return interleave ? (start ^ cnt) : (start + cnt); // RL10
  endfunction

  // Pending writes are applied oldest first, so the newest lane value wins
  function automatic logic [fts_pkg::WORD_W-1:0] fts_forward(
    input logic [fts_pkg::WORD_W-1:0]                        word,
    input logic [fts_pkg::FIFO_DEPTH-1:0][fts_pkg::ENTRY_W-1:0] snap,
    input logic [fts_pkg::FIFO_DEPTH-1:0]                    live,
    input logic [fts_pkg::ADDR_W-1:0]                        addr
  );
    fts_pkg::fts_entry_t        e;
    logic [fts_pkg::WORD_W-1:0] w;
    w = word;
    for (int i = 0; i < fts_pkg::FIFO_DEPTH; i++) begin
      e = snap[i];
      if (live[i] && (e.addr == addr)) begin
        w = fts_merge(w, e.data, e.lanes_n);
      end
    end
    return w;
  endfunction

  // ==========================================================================
  // Cycle decode
  always_comb begin
    qual     = !clock_qualify_n_i; // RL3
    // Sleep forces a deselect so no access starts while powered down
    chip_sel = !select_low_first_n_i && select_high_second_i
               && !select_low_third_n_i && !sleep_pin_i; // RL7 RL11
    load     = !burst_step_or_load_i; // RL13
    step_cnt = st.cnt + 2'h1; // RL12
    op       = fts_pkg::FTS_OP_IDLE;
    eff_addr = addr_i;
    if (chip_sel) begin
      if (load) begin
        op       = write_n_i ? fts_pkg::FTS_OP_READ : fts_pkg::FTS_OP_WRITE; // RL5
        eff_addr = addr_i;
      end else begin
        // An advance after a deselect has no burst to continue
        op       = st.last_op;
        eff_addr = {st.base[fts_pkg::ADDR_W-1:fts_pkg::BURST_W],
                    fts_burst_low(st.start, step_cnt, burst_interleave_i)}; // RL10 RL12
      end
    end
  end

  // ==========================================================================
  // Write queue feed and read path
  always_comb begin
    push_entry.addr    = st.pend_addr;
    push_entry.lanes_n = st.pend_lanes;
    push_entry.data    = dq_i; // RL6
    wq.push_valid      = qual && st.pend_wr; // RL6
    wq.push_data       = push_entry;
    // Reads take the array first; a full queue overrides so no write is lost
    wq.pop_ready       = qual && ((op != fts_pkg::FTS_OP_READ) || wq.live[fts_pkg::FIFO_DEPTH-1]);
    head               = wq.pop_data;
    read_word          = fts_forward(array_q[eff_addr], wq.snap, wq.live, eff_addr); // RL4
    if (wq.push_valid && (st.pend_addr == eff_addr)) begin
      read_word = fts_merge(read_word, dq_i, st.pend_lanes); // RL4
    end
  end

  // ==========================================================================
  // Next state
  always_comb begin
    next_st = st;
    if (qual) begin // RL3
      next_st.pend_wr    = (op == fts_pkg::FTS_OP_WRITE); // RL17
      next_st.pend_addr  = eff_addr;
      next_st.pend_lanes = lane_write_sel_n_i; // RL5
      next_st.drive      = (op == fts_pkg::FTS_OP_READ); // RL9 RL16
      next_st.low_power  = (op == fts_pkg::FTS_OP_IDLE); // RL11
      if (op == fts_pkg::FTS_OP_READ) begin
        next_st.dq = read_word; // RL16
      end
      if (!chip_sel) begin
        next_st.last_op = fts_pkg::FTS_OP_IDLE;
      end else if (load) begin
        next_st.base    = addr_i; // RL12
        next_st.start   = addr_i[fts_pkg::BURST_W-1:0];
        next_st.cnt     = fts_pkg::BURST_RST;
        next_st.last_op = op;
      end else if (st.last_op != fts_pkg::FTS_OP_IDLE) begin
        next_st.cnt = step_cnt; // RL13
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st.base       <= fts_pkg::ADDR_RST;
      st.start      <= fts_pkg::BURST_RST;
      st.cnt        <= fts_pkg::BURST_RST;
      st.last_op    <= fts_pkg::FTS_OP_IDLE;
      st.pend_wr    <= 1'b0;
      st.pend_addr  <= fts_pkg::ADDR_RST;
      st.pend_lanes <= fts_pkg::LANES_RST;
      st.dq         <= fts_pkg::WORD_RST;
      st.drive      <= 1'b0;
      st.low_power  <= 1'b1;
    end else begin
      st <= next_st; // RL2
    end
  end

  // ==========================================================================
  // Storage array, written from the head of the queue
  always_ff @(posedge clk_i) begin
    if (wq.pop_valid && wq.pop_ready) begin
      array_q[head.addr] <= fts_merge(array_q[head.addr], head.data, head.lanes_n); // RL1 RL6
    end
  end

  fts_fifo #(
    .W (fts_pkg::ENTRY_W),
    .D (fts_pkg::FIFO_DEPTH)
  ) u_wq (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .q     (wq)
  );

  // ==========================================================================
  // Outputs
  assign dq_o        = st.dq;
  // Enable gate stays combinational so the drivers let go without a clock
  assign dq_oe_o     = st.drive && !out_enable_n_i; // RL8
  assign low_power_o = st.low_power;

  // ==========================================================================
  // Checks
  a_suspend_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RL3
    clock_qualify_n_i |=> (st == $past(st)))
    else $error("State changed during a suspended cycle");

  a_oe_async: assert property (@(posedge clk_i) disable iff (rst_i) // RL8
    out_enable_n_i |-> !dq_oe_o)
    else $error("Data driven while output enable is high");

  a_write_tristate: assert property (@(posedge clk_i) disable iff (rst_i) // RL9
    qual && (op == fts_pkg::FTS_OP_WRITE) |=> !dq_oe_o)
    else $error("Data driven during a write data cycle");

  a_read_flow: assert property (@(posedge clk_i) disable iff (rst_i) // RL16
    qual && (op == fts_pkg::FTS_OP_READ) ##1 !out_enable_n_i |-> dq_oe_o)
    else $error("Read data not driven in the cycle after its address");

  a_write_read_mix: assert property (@(posedge clk_i) disable iff (rst_i) // RL4
    qual && chip_sel && load && !write_n_i
    ##1 qual && chip_sel && load && write_n_i |=> st.drive)
    else $error("Read after write did not drive data");

  a_write_queued: assert property (@(posedge clk_i) disable iff (rst_i) // RL6
    qual && (op == fts_pkg::FTS_OP_WRITE) ##1 qual
    |-> wq.push_valid && wq.push_ready && (st.pend_addr == $past(eff_addr)))
    else $error("Write data not queued at its address");

  a_select_decode: assert property (@(posedge clk_i) disable iff (rst_i) // RL7
    qual && (select_low_first_n_i || !select_high_second_i || select_low_third_n_i)
    |=> low_power_o && !st.drive && !st.pend_wr)
    else $error("Access started while deselected");

  a_sleep_power: assert property (@(posedge clk_i) disable iff (rst_i) // RL11
    qual && sleep_pin_i |=> low_power_o)
    else $error("Sleep did not enter low power");

  a_burst_step: assert property (@(posedge clk_i) disable iff (rst_i) // RL13
    qual && chip_sel && !load && (st.last_op != fts_pkg::FTS_OP_IDLE)
    |=> st.cnt == $past(st.cnt) + 2'h1)
    else $error("Burst counter did not advance");

  a_load_seed: assert property (@(posedge clk_i) disable iff (rst_i) // RL12
    qual && chip_sel && load
    |=> (st.start == $past(addr_i[1:0])) && (st.cnt == 2'h0))
    else $error("Burst counter not seeded from address");

endmodule

`default_nettype wire

// ### dv/fts_ctrl_model.sv
// Memory controller model that drives the SRAM port pins
`timescale 1ns/10ps
`default_nettype none

module fts_ctrl_model (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic [6:0]                  op_ctl_i,
  input  wire logic [fts_pkg::ADDR_W-1:0]  op_addr_i,
  input  wire logic [fts_pkg::LANES-1:0]   op_lanes_n_i,
  input  wire logic [fts_pkg::WORD_W-1:0]  op_data_i,
  output logic      [6:0]                  ctl_o,
  output logic      [fts_pkg::ADDR_W-1:0]  addr_o,
  output logic      [fts_pkg::LANES-1:0]   lanes_n_o,
  output logic      [fts_pkg::WORD_W-1:0]  dq_o
);
  // ==========================================================================
  // Pin drive
  // ctl bits: sleep, qualify_n, first_n, second, third_n, write_n, step
  logic [fts_pkg::WORD_W-1:0] data_q;
  logic                       last_wr;
  logic                       sel;
  logic                       wr_now;

  assign sel    = ctl_o[4:2] == 3'b010 && !ctl_o[6];
  assign wr_now = sel && (ctl_o[0] ? last_wr : !ctl_o[1]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_o     <= 7'h16;
      addr_o    <= '0;
      lanes_n_o <= 4'hf;
      data_q    <= '0;
      last_wr   <= 1'b0;
      dq_o      <= '0;
    end else begin
      if (!ctl_o[5]) begin
        // Idle bus toggles so a stale word never reads as a match
        dq_o    <= wr_now ? data_q : ~dq_o;
        last_wr <= wr_now;
      end
      // Command, address and lanes change only just after an edge
      ctl_o     <= op_ctl_i;
      addr_o    <= op_addr_i;
      lanes_n_o <= op_lanes_n_i;
      data_q    <= op_data_i;
    end
  end
endmodule

`default_nettype wire

// ### dv/fts_sram_port_tb.sv
// Self-checking bench for the flow-through SRAM port
`timescale 1ns/10ps
`default_nettype none

module fts_sram_port_tb;
  localparam logic [6:0] RD   = 7'h0a;
  localparam logic [6:0] WR   = 7'h08;
  localparam logic [6:0] ST   = 7'h0b;
  localparam logic [6:0] NO   = 7'h16;
  localparam logic [6:0] HOLD = 7'h2a;
  localparam logic [6:0] DESEL [4] = '{7'h1a, 7'h02, 7'h0e, 7'h4a};
  localparam logic [18:0] ADDRS [4] = '{19'h00000, 19'h00005, 19'h40003, 19'h7ffff};

  logic                       clk_i = 1'b0;
  logic                       rst_i = 1'b1;
  logic                       ileave = 1'b0;
  logic                       oe_n = 1'b0;
  logic [6:0]                 op_ctl = NO;
  logic [fts_pkg::ADDR_W-1:0] op_addr = '0;
  logic [fts_pkg::LANES-1:0]  op_lanes = '1;
  logic [fts_pkg::WORD_W-1:0] op_data = '0;
  logic [6:0]                 m_ctl;
  logic [fts_pkg::ADDR_W-1:0] m_addr, base, ca, pa, a;
  logic [fts_pkg::LANES-1:0]  m_lanes, pl, ln;
  logic [fts_pkg::WORD_W-1:0] m_dq, dq_o, e_dq;
  logic                       dq_oe_o, low_power_o, e_drv, e_lp, pend;
  logic                       cs = 1'b0;
  logic [1:0]                 cnt, op;
  logic [31:0]                rs = 32'h00004f40;
  logic [31:0]                r;
  logic [fts_pkg::WORD_W-1:0] mem [int];
  int                         bad_count = 0;
  int                         n_compared = 0;

  always #4 clk_i = ~clk_i;

  fts_sram_port fts_sram_port_i (
    .clk_i                (clk_i),
    .rst_i                (rst_i),
    .addr_i               (m_addr),
    .select_low_first_n_i (m_ctl[4]),
    .select_high_second_i (m_ctl[3]),
    .select_low_third_n_i (m_ctl[2]),
    .clock_qualify_n_i    (m_ctl[5]),
    .write_n_i            (m_ctl[1]),
    .lane_write_sel_n_i   (m_lanes),
    .burst_step_or_load_i (m_ctl[0]),
    .burst_interleave_i   (ileave),
    .sleep_pin_i          (m_ctl[6]),
    .out_enable_n_i       (oe_n),
    .dq_i                 (m_dq),
    .dq_o                 (dq_o),
    .dq_oe_o              (dq_oe_o),
    .low_power_o          (low_power_o)
  );

  fts_ctrl_model fts_ctrl_model_i (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .op_ctl_i     (op_ctl),
    .op_addr_i    (op_addr),
    .op_lanes_n_i (op_lanes),
    .op_data_i    (op_data),
    .ctl_o        (m_ctl),
    .addr_o       (m_addr),
    .lanes_n_o    (m_lanes),
    .dq_o         (m_dq)
  );

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  function automatic logic [35:0] rnd36();
    logic [31:0] hi;
    hi = rnd();
    return {hi[3:0], rnd()};
  endfunction

  function automatic logic [35:0] rd(input logic [18:0] ad);
    return mem.exists(int'(ad)) ? mem[int'(ad)] : 36'hx;
  endfunction

  function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n,
                                        input logic [3:0] l);
    merge = o;
    for (int k = 0; k < 4; k++) if (!l[k]) merge[9*k +: 9] = n[9*k +: 9];
  endfunction

  task automatic chk_word(input string n, input logic [35:0] e, input logic [35:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %b got %b", n, e, g);
    end
  endtask

  task automatic issue(input logic [6:0] c, input logic [18:0] ad, input logic [3:0] l,
                       input logic [35:0] d);
    @(posedge clk_i);
    op_ctl   <= c;
    op_addr  <= ad;
    op_lanes <= l;
    op_data  <= d;
  endtask

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Reference of the port as the pins see it
  always @(posedge clk_i) begin
    if (rst_i) begin
      op    = 2'd0;
      pend  = 1'b0;
      e_dq  = '0;
      e_drv = 1'b0;
      e_lp  = 1'b1;
    end else if (!m_ctl[5]) begin
      if (pend) mem[int'(pa)] = merge(rd(pa), m_dq, pl);
      pend = 1'b0;
      if (m_ctl[4:2] != 3'b010 || m_ctl[6]) op = 2'd0;
      else if (!m_ctl[0]) begin
        base = m_addr;
        cnt  = 2'd0;
        op   = m_ctl[1] ? 2'd1 : 2'd2;
      end else if (op != 2'd0) cnt = cnt + 2'd1;
      ca    = {base[18:2], ileave ? base[1:0] ^ cnt : base[1:0] + cnt};
      e_drv = op == 2'd1;
      e_lp  = op == 2'd0;
      if (op == 2'd1) e_dq = rd(ca);
      if (op == 2'd2) begin
        pend = 1'b1;
        pa   = ca;
        pl   = m_lanes;
      end
    end
    #1;
    chk_bit("drive", e_drv & !oe_n, dq_oe_o);
    chk_bit("low_power", e_lp, low_power_o);
    if (!$isunknown(e_dq)) chk_word("read_data", e_dq, dq_o);
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    test_done;
  end

  // ==========================================================================
  // Scenarios
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ADDRS[i]) begin
      issue(WR, ADDRS[i], 4'h0, rnd36());
      issue(RD, ADDRS[i], 4'hf, '0);
      issue(WR, ADDRS[i], ~(4'h1 << i), rnd36());
      issue(RD, ADDRS[i], 4'hf, '0);
    end
    issue(WR, 19'h00010, 4'h0, rnd36());
    issue(HOLD, 19'h00000, 4'hf, '0);
    issue(HOLD, 19'h00033, 4'hf, '0);
    issue(RD, 19'h00010, 4'hf, '0);
    foreach (DESEL[i]) begin
      issue(DESEL[i], 19'h00010, 4'hf, '0);
      issue(RD, 19'h00010, 4'hf, '0);
    end
    for (int m = 0; m < 2; m++) begin
      issue(NO, '0, 4'hf, '0);
      issue(NO, '0, 4'hf, '0);
      ileave <= m[0];
      // Odd start words make the linear and interleaved orders differ
      issue(WR, 19'h00121, 4'h0, rnd36());
      repeat (3) issue(ST, '0, 4'h0, rnd36());
      for (int k = 0; k < 4; k++) issue(RD, 19'h00120 + 19'(k), 4'hf, '0);
      issue(RD, 19'h00123, 4'hf, '0);
      repeat (4) issue(ST, '0, 4'hf, '0);
    end
    // Long write run then reads back, every word through the queue
    for (int k = 0; k < 20; k++) issue(WR, 19'h00200 + 19'(k), 4'h0, rnd36());
    for (int k = 0; k < 20; k++) issue(RD, 19'h00200 + 19'(k), 4'hf, '0);
    repeat (3) issue(RD, 19'h00200, 4'hf, '0);
    @(negedge clk_i);
    chk_bit("oe_on", 1'b1, dq_oe_o);
    oe_n = 1'b1;
    #1 chk_bit("oe_off", 1'b0, dq_oe_o);
    @(negedge clk_i);
    oe_n = 1'b0;
    // Whole words first, so random partial writes leave no unknown lanes
    for (int k = 0; k < 16; k++) begin
      issue(WR, 19'(k), 4'h0, rnd36());
      issue(WR, 19'h7fff0 + 19'(k), 4'h0, rnd36());
    end
    ln = 4'h0;
    for (int k = 0; k < 600; k++) begin
      r = rnd();
      a = {{15{r[31]}}, r[7:4]};
      case (r[2:0])
        3'd0, 3'd1, 3'd2: issue(RD, a, ln, '0);
        3'd3, 3'd4: begin
          ln = r[11:8];
          issue(WR, a, ln, rnd36());
        end
        3'd5: issue(cs ? ST : NO, a, ln, rnd36());
        3'd6: issue(HOLD, a, ln, '0);
        default: issue(NO, a, ln, '0);
      endcase
      cs = r[2:0] < 3'd5 || (r[2:0] < 3'd7 && cs);
    end
    repeat (4) issue(NO, '0, 4'hf, '0);
    test_done;
  end
endmodule

`default_nettype wire
